// ---- design/uhb_pkg.sv ----
package uhb_pkg;
	// clock rates in kHz
	localparam int CLK_KHZ      = 125000;
	localparam int CPU_SLOW_KHZ = 12000;
	localparam int CPU_FAST_KHZ = 48000;
	localparam int IF_FAST_KHZ  = 48000;
	localparam int IF_SLOW_KHZ  = 30000;
	// divider counts, rounded down so the rate never falls below the figure
	localparam logic [3:0] CPU_SLOW_DIV = 4'(CLK_KHZ / CPU_SLOW_KHZ);
	localparam logic [3:0] CPU_FAST_DIV = 4'(CLK_KHZ / CPU_FAST_KHZ);
	localparam logic [3:0] IF_FAST_DIV  = 4'(CLK_KHZ / IF_FAST_KHZ);
	localparam logic [3:0] IF_SLOW_DIV  = 4'(CLK_KHZ / IF_SLOW_KHZ);
	localparam logic [3:0] DIV_ONE      = 4'h1;
	// register byte addresses
	localparam logic [7:0] A_IFACE_CFG = 8'h00;
	localparam logic [7:0] A_PROC_CTRL = 8'h04;
	localparam logic [7:0] A_EP_CFG    = 8'h08;
	localparam logic [7:0] A_FIFO_INIT = 8'h0C;
	localparam logic [7:0] A_COMMAND   = 8'h10;
	localparam logic [7:0] A_STATUS    = 8'h14;
	localparam logic [7:0] A_WF_SELECT = 8'h18;
	localparam logic [7:0] A_PORT_CTRL = 8'h1C;
	// interface_config fields
	localparam int B_CLK_SRC  = 7;
	localparam int B_CLK_FREQ = 6;
	localparam int B_CLK_OE   = 5;
	localparam int B_DEBUG    = 2;
	localparam logic [1:0] MODE_ENGINE   = 2'h2;
	localparam logic [7:0] IFACE_CFG_RST = 8'h00;
	// processor_control clock speed field
	localparam int SPD_LSB = 3;
	localparam logic [1:0] SPD_48       = 2'h2;
	localparam logic [7:0] PROC_CTRL_RST = 8'h00;
	// port register reset parks rw_n, strobe_n and bil high so no false strobe leaves reset
	localparam logic [7:0] PORT_CTRL_RST = 8'h13;
	// endpoint configuration, bulk 512 bytes 4x buffered
	localparam logic [7:0] EP_OUT_CFG = 8'hA0;
	localparam logic [7:0] EP_IN_CFG  = 8'hE0;
	// fifo_reset_control codes
	localparam logic [7:0] FR_NAK_ALL = 8'h80;
	localparam logic [7:0] FR_OUT_EP  = 8'h02;
	localparam logic [7:0] FR_IN_EP   = 8'h06;
	localparam logic [7:0] FR_RESUME  = 8'h00;
	// waveform indices and request codes
	localparam logic [7:0] WF_FIRST  = 8'h1E;
	localparam logic [7:0] WF_SECOND = 8'h4E;
	localparam logic [7:0] WF_RST    = 8'h00;
	localparam logic [7:0] CMD_CTRL  = 8'hB6;
	localparam logic [7:0] CMD_ADDR  = 8'hB7;
	// engine debug state codes
	localparam logic [2:0] ES_S0   = 3'h0;
	localparam logic [2:0] ES_S1   = 3'h1;
	localparam logic [2:0] ES_S2   = 3'h2;
	localparam logic [2:0] ES_IDLE = 3'h7;
endpackage

// ---- design/uhb_wave_if.sv ----
`timescale 1ns/1ns
interface uhb_wave_if;
	logic       tick;
	logic       start;
	logic [7:0] index;
	logic [7:0] data;
	logic       busy;
	logic       rw_n;
	logic       strobe_n;
	logic       bil;
	logic [7:0] d_o;
	logic       d_oe;
	logic [2:0] state;
	modport eng (input tick, start, index, data,
		output busy, rw_n, strobe_n, bil, d_o, d_oe, state);
	modport seq (output tick, start, index, data,
		input busy, rw_n, strobe_n, bil, d_o, d_oe, state);
endinterface

// ---- design/uhb_wave.sv ----
`timescale 1ns/1ns
module uhb_wave (
	input  wire logic clk,
	input  wire logic rst,
	uhb_wave_if.eng   w
);
	import uhb_pkg::*;

	typedef enum logic [3:0] {
		WV_IDLE = 4'b0001,
		WV_S0   = 4'b0010,
		WV_S1   = 4'b0100,
		WV_S2   = 4'b1000
	} uhb_wv_t;

	uhb_wv_t    st_r, st_nxt;
	logic       bil_r, bil_nxt;
	logic [7:0] d_r, d_nxt;

	always_comb begin
		st_nxt = st_r;
		bil_nxt = bil_r;
		d_nxt = d_r;
		unique case (st_r)
			WV_IDLE: begin
				// unknown indices run no waveform
				if (w.start && (w.index == WF_FIRST || w.index == WF_SECOND)) begin
					st_nxt = WV_S0;
					d_nxt = w.data;
					bil_nxt = (w.index == WF_SECOND);
				end
			end
			// each state lasts until the next interface clock tick
			WV_S0: if (w.tick) st_nxt = WV_S1;
			WV_S1: if (w.tick) st_nxt = WV_S2;
			WV_S2: if (w.tick) st_nxt = WV_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= WV_IDLE;
			bil_r <= 1'b1;
			d_r <= 8'h00;
		end else begin
			st_r <= st_nxt;
			bil_r <= bil_nxt;
			d_r <= d_nxt;
		end
	end

	assign w.busy = (st_r != WV_IDLE);
	// write direction held low while active
	assign w.rw_n = (st_r == WV_IDLE);
	assign w.strobe_n = (st_r != WV_S1);
	assign w.bil = bil_r;
	assign w.d_o = d_r;
	assign w.d_oe = (st_r == WV_S1) || (st_r == WV_S2);
	assign w.state = (st_r == WV_S0) ? ES_S0 :
		(st_r == WV_S1) ? ES_S1 :
		(st_r == WV_S2) ? ES_S2 : ES_IDLE;
endmodule

// ---- design/uhb_bridge.sv ----
// What this block does
// - interface_config bit 7 set runs the engine from the internal clock.
// - interface_config bit 6 set makes the internal interface clock 48 MHz.
// - interface_config bit 5 set drives the interface clock out on its pin.
// - interface_config bit 3 has no effect in engine mode.
// - bit 2 set shows engine state on state_debug_outputs in engine mode; port mode gives 0.
// - mode field 10 selects engine mode, otherwise plain port pins.
// - processor clock is 12 MHz from reset, 48 MHz when speed field written.
// - a single write runs the waveform indexed by waveform_select, 1E or 4E.
// - control register addressed with both register select pins low.
// - address register addressed with select hi one and select lo zero.
// - wait for host port ready before selecting and writing.
// - address request carries low byte first, then high byte.
// - re-arm control endpoint buffer, wait until not busy, then read payload.
// - bulk out and bulk in endpoints are 4x buffered, 512-byte packets.
// - fifo init: refuse all, reset out, reset in, resume.
// - external_irq_pin is a falling-edge, enabled external interrupt.
// - first-byte wave holds byte identify low, second high, write direction low.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module uhb_bridge (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ext_iface_clock,
	input  wire logic        host_port_ready,
	input  wire logic        ep_buf_busy,
	input  wire logic [7:0]  ep_buf_byte0,
	input  wire logic [7:0]  ep_buf_byte1,
	input  wire logic        external_irq_pin,
	output logic             ep_buf_rearm,
	output logic             interface_clock,
	output logic [2:0]       state_debug_outputs,
	output logic             register_select_hi,
	output logic             register_select_lo,
	output logic             host_rw_n,
	output logic             host_strobe_n,
	output logic             byte_identify_line,
	output logic [7:0]       host_data_o,
	output logic             host_data_oe,
	output logic [7:0]       fifo_reset_control,
	output logic             fifo_reset_we,
	output logic             refuse_all_host_traffic,
	output logic             processor_tick
);
	import uhb_pkg::*;

	typedef enum logic [7:0] {
		SQ_IDLE  = 8'b0000_0001,
		SQ_REARM = 8'b0000_0010,
		SQ_BUF   = 8'b0000_0100,
		SQ_RDY   = 8'b0000_1000,
		SQ_B1    = 8'b0001_0000,
		SQ_W1    = 8'b0010_0000,
		SQ_B2    = 8'b0100_0000,
		SQ_W2    = 8'b1000_0000
	} uhb_sq_t;

	uhb_wave_if wv ();

	uhb_wave u_wave (
		.clk (core_clk),
		.rst (rst),
		.w   (wv)
	);

	////////////////////////////////////////////////////////////////////////////
	// state

	logic [7:0]  iface_cfg_r, iface_cfg_nxt;
	logic [7:0]  proc_ctrl_r, proc_ctrl_nxt;
	logic [7:0]  wf_sel_r, wf_sel_nxt;
	logic [7:0]  port_r, port_nxt;
	logic [7:0]  cmd_r, cmd_nxt;
	logic        irq_en_r, irq_en_nxt;
	logic        irq_flag_r, irq_flag_nxt;
	logic        irq_pin_r;
	logic [31:0] prdata_r, prdata_nxt;
	logic        pready_r, pready_nxt;
	logic        pslverr_r, pslverr_nxt;
	uhb_sq_t     sq_r, sq_nxt;
	logic        wv_start_r, wv_start_nxt;
	logic [7:0]  wv_data_r, wv_data_nxt;
	logic        sel_hi_r, sel_hi_nxt;
	logic        sel_lo_r, sel_lo_nxt;
	logic        rearm_r, rearm_nxt;
	logic [2:0]  fi_step_r, fi_step_nxt;
	logic [7:0]  fr_code_r, fr_code_nxt;
	logic        fr_we_r, fr_we_nxt;
	logic        nak_r, nak_nxt;
	logic [3:0]  cpu_cnt_r, cpu_cnt_nxt;
	logic        cpu_tick_r, cpu_tick_nxt;
	logic [3:0]  if_cnt_r, if_cnt_nxt;
	logic        if_tick_r, if_tick_nxt;
	logic        ext_clk_r;
	logic        interface_clock_out_r, interface_clock_out_nxt;

	logic        wr_acc;
	logic        setup;
	logic        engine_mode;
	logic [3:0]  cpu_div;
	logic [3:0]  if_div;

	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pready_r && pwrite;
	assign engine_mode = (iface_cfg_r[1:0] == MODE_ENGINE);
	assign cpu_div = (proc_ctrl_r[SPD_LSB +: 2] == SPD_48) ? CPU_FAST_DIV : CPU_SLOW_DIV;
	assign if_div = iface_cfg_r[B_CLK_FREQ] ? IF_FAST_DIV : IF_SLOW_DIV;

	////////////////////////////////////////////////////////////////////////////
	// clock dividers

	always_comb begin
		cpu_tick_nxt = (cpu_cnt_r == DIV_ONE);
		cpu_cnt_nxt = cpu_tick_nxt ? cpu_div : cpu_cnt_r - DIV_ONE;
		if_cnt_nxt = (if_cnt_r == DIV_ONE) ? if_div : if_cnt_r - DIV_ONE;
		if (iface_cfg_r[B_CLK_SRC])
			if_tick_nxt = (if_cnt_r == DIV_ONE);
		else
			if_tick_nxt = ext_iface_clock && !ext_clk_r;
		interface_clock_out_nxt = iface_cfg_r[B_CLK_OE] && (if_tick_r ^ interface_clock_out_r);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cpu_cnt_r <= CPU_SLOW_DIV;
			cpu_tick_r <= 1'b0;
			if_cnt_r <= IF_SLOW_DIV;
			if_tick_r <= 1'b0;
			ext_clk_r <= 1'b0;
			interface_clock_out_r <= 1'b0;
		end else begin
			cpu_cnt_r <= cpu_cnt_nxt;
			cpu_tick_r <= cpu_tick_nxt;
			if_cnt_r <= if_cnt_nxt;
			if_tick_r <= if_tick_nxt;
			ext_clk_r <= ext_iface_clock;
			interface_clock_out_r <= interface_clock_out_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// apb registers

	always_comb begin
		iface_cfg_nxt = iface_cfg_r;
		proc_ctrl_nxt = proc_ctrl_r;
		port_nxt = port_r;
		irq_en_nxt = irq_en_r;
		prdata_nxt = prdata_r;
		pready_nxt = setup;
		pslverr_nxt = 1'b0;
		if (setup) begin
			prdata_nxt = 32'h0000_0000;
			unique case (paddr)
				A_IFACE_CFG: prdata_nxt[7:0] = iface_cfg_r;
				A_PROC_CTRL: prdata_nxt[7:0] = proc_ctrl_r;
				A_EP_CFG:    prdata_nxt[15:0] = {EP_IN_CFG, EP_OUT_CFG};
				A_FIFO_INIT: prdata_nxt[8:0] = {nak_r, fr_code_r};
				A_COMMAND:   prdata_nxt[7:0] = cmd_r;
				A_STATUS:    prdata_nxt[7:0] = {irq_en_r, irq_flag_r, host_port_ready,
					ep_buf_busy, sq_r != SQ_IDLE, wv.state};
				A_WF_SELECT: prdata_nxt[7:0] = wf_sel_r;
				A_PORT_CTRL: prdata_nxt[7:0] = port_r;
				default:     pslverr_nxt = 1'b1;
			endcase
		end
		if (wr_acc) begin
			unique case (paddr)
				// asynchronous bit stored but unused in engine mode
				A_IFACE_CFG: iface_cfg_nxt = pwdata[7:0];
				A_PROC_CTRL: proc_ctrl_nxt = pwdata[7:0];
				A_PORT_CTRL: port_nxt = pwdata[7:0];
				A_STATUS:    irq_en_nxt = pwdata[7];
				default:     ;
			endcase
		end
	end

	// falling edge on the interrupt pin; set beats clear
	always_comb begin
		irq_flag_nxt = irq_flag_r;
		if (wr_acc && paddr == A_STATUS && pwdata[6])
			irq_flag_nxt = 1'b0;
		if (irq_en_r && irq_pin_r && !external_irq_pin)
			irq_flag_nxt = 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			iface_cfg_r <= IFACE_CFG_RST;
			proc_ctrl_r <= PROC_CTRL_RST;
			port_r <= PORT_CTRL_RST;
			irq_en_r <= 1'b1;
			irq_flag_r <= 1'b0;
			irq_pin_r <= 1'b1;
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			iface_cfg_r <= iface_cfg_nxt;
			proc_ctrl_r <= proc_ctrl_nxt;
			port_r <= port_nxt;
			irq_en_r <= irq_en_nxt;
			irq_flag_r <= irq_flag_nxt;
			irq_pin_r <= external_irq_pin;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// fifo init sequence, one step per processor tick

	always_comb begin
		fi_step_nxt = fi_step_r;
		fr_code_nxt = fr_code_r;
		fr_we_nxt = 1'b0;
		nak_nxt = nak_r;
		if (wr_acc && paddr == A_FIFO_INIT && pwdata[0] && fi_step_r == 3'h0)
			fi_step_nxt = 3'h1;
		else if (cpu_tick_r && fi_step_r != 3'h0) begin
			fr_we_nxt = 1'b1;
			fi_step_nxt = (fi_step_r == 3'h4) ? 3'h0 : fi_step_r + 3'h1;
			// refuse all, reset out, reset in, resume
			unique case (fi_step_r)
				3'h1: fr_code_nxt = FR_NAK_ALL;
				3'h2: fr_code_nxt = FR_OUT_EP | FR_NAK_ALL;
				3'h3: fr_code_nxt = FR_IN_EP | FR_NAK_ALL;
				default: fr_code_nxt = FR_RESUME;
			endcase
			nak_nxt = (fi_step_r != 3'h4);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			fi_step_r <= 3'h0;
			fr_code_r <= FR_RESUME;
			fr_we_r <= 1'b0;
			nak_r <= 1'b0;
		end else begin
			fi_step_r <= fi_step_nxt;
			fr_code_r <= fr_code_nxt;
			fr_we_r <= fr_we_nxt;
			nak_r <= nak_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// vendor request sequencer

	always_comb begin
		sq_nxt = sq_r;
		cmd_nxt = cmd_r;
		wf_sel_nxt = wf_sel_r;
		wv_start_nxt = 1'b0;
		wv_data_nxt = wv_data_r;
		sel_hi_nxt = sel_hi_r;
		sel_lo_nxt = sel_lo_r;
		rearm_nxt = 1'b0;
		unique case (sq_r)
			SQ_IDLE: begin
				if (wr_acc && paddr == A_COMMAND && engine_mode &&
						(pwdata[7:0] == CMD_CTRL || pwdata[7:0] == CMD_ADDR)) begin
					cmd_nxt = pwdata[7:0];
					sq_nxt = SQ_REARM;
				end
			end
			// re-arm then wait for the buffer
			SQ_REARM: if (cpu_tick_r) begin
				rearm_nxt = 1'b1;
				sq_nxt = SQ_BUF;
			end
			SQ_BUF: if (cpu_tick_r && !ep_buf_busy) sq_nxt = SQ_RDY;
			SQ_RDY: if (cpu_tick_r && host_port_ready) begin
				sel_hi_nxt = (cmd_r == CMD_ADDR);
				sel_lo_nxt = 1'b0;
				wf_sel_nxt = WF_FIRST;
				sq_nxt = SQ_B1;
			end
			SQ_B1: if (cpu_tick_r) begin
				wv_data_nxt = ep_buf_byte0;
				wv_start_nxt = 1'b1;
				sq_nxt = SQ_W1;
			end
			// second byte only after the first wave idles
			SQ_W1: if (cpu_tick_r && !wv.busy && !wv_start_r) begin
				wf_sel_nxt = WF_SECOND;
				sq_nxt = SQ_B2;
			end
			SQ_B2: if (cpu_tick_r) begin
				wv_data_nxt = ep_buf_byte1;
				wv_start_nxt = 1'b1;
				sq_nxt = SQ_W2;
			end
			SQ_W2: if (!wv.busy && !wv_start_r) sq_nxt = SQ_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sq_r <= SQ_IDLE;
			cmd_r <= 8'h00;
			wf_sel_r <= WF_RST;
			wv_start_r <= 1'b0;
			wv_data_r <= 8'h00;
			sel_hi_r <= 1'b0;
			sel_lo_r <= 1'b0;
			rearm_r <= 1'b0;
		end else begin
			sq_r <= sq_nxt;
			cmd_r <= cmd_nxt;
			wf_sel_r <= wf_sel_nxt;
			wv_start_r <= wv_start_nxt;
			wv_data_r <= wv_data_nxt;
			sel_hi_r <= sel_hi_nxt;
			sel_lo_r <= sel_lo_nxt;
			rearm_r <= rearm_nxt;
		end
	end

	assign wv.tick = if_tick_r;
	assign wv.start = wv_start_r;
	assign wv.index = wf_sel_r;
	assign wv.data = wv_data_r;

	////////////////////////////////////////////////////////////////////////////
	// pin stage, registered so every output is a flop

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_debug_outputs <= 3'h0;
			register_select_hi <= 1'b0;
			register_select_lo <= 1'b0;
			host_rw_n <= 1'b1;
			host_strobe_n <= 1'b1;
			byte_identify_line <= 1'b1;
			host_data_o <= 8'h00;
			host_data_oe <= 1'b0;
		end else begin
			state_debug_outputs <= (iface_cfg_r[B_DEBUG] && engine_mode) ? wv.state : 3'h0;
			// port mode drives pins from the port register
			register_select_hi <= engine_mode ? sel_hi_r : port_r[3];
			register_select_lo <= engine_mode ? sel_lo_r : port_r[2];
			host_rw_n <= engine_mode ? wv.rw_n : port_r[0];
			host_strobe_n <= engine_mode ? wv.strobe_n : port_r[1];
			byte_identify_line <= engine_mode ? wv.bil : port_r[4];
			host_data_o <= wv.d_o;
			host_data_oe <= engine_mode && wv.d_oe;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign ep_buf_rearm = rearm_r;
	assign interface_clock = interface_clock_out_r;
	assign fifo_reset_control = fr_code_r;
	assign fifo_reset_we = fr_we_r;
	assign refuse_all_host_traffic = nak_r;
	assign processor_tick = cpu_tick_r;
endmodule

// ---- tb/uhb_bridge_asserts.sv ----
`timescale 1ns/1ns
module uhb_bridge_asserts (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic host_port_ready,
	input wire logic ep_buf_busy,
	input wire logic ep_buf_rearm,
	input wire logic register_select_hi,
	input wire logic register_select_lo,
	input wire logic host_rw_n,
	input wire logic host_strobe_n,
	input wire logic byte_identify_line,
	input wire logic host_data_oe,
	input wire logic fifo_reset_we,
	input wire logic processor_tick
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	strobe_write_a: assert property (!host_strobe_n |-> !host_rw_n && host_data_oe)
		else $error("strobe without write drive");
	bil_hold_a: assert property (!host_rw_n && $past(!host_rw_n) |-> $stable(byte_identify_line))
		else $error("byte identify moved mid wave");
	select_hold_a: assert property (!host_rw_n && $past(!host_rw_n) |->
		$stable({register_select_hi, register_select_lo}))
		else $error("register select moved mid wave");
	idle_gap_a: assert property ($rose(host_rw_n) |=> host_rw_n)
		else $error("second wave without idle");
	buf_free_a: assert property (!host_strobe_n |-> !ep_buf_busy)
		else $error("strobe while buffer busy");
	rearm_pulse_a: assert property (ep_buf_rearm |=> !ep_buf_rearm)
		else $error("rearm longer than one cycle");
	ready_first_a: assert property ($fell(host_rw_n) && !byte_identify_line |-> host_port_ready)
		else $error("write started while port not ready");
	fifo_step_a: assert property (fifo_reset_we |=> !fifo_reset_we)
		else $error("fifo codes issued back to back");
	tick_pulse_a: assert property (processor_tick |=> !processor_tick)
		else $error("processor tick wider than one cycle");
endmodule

bind uhb_bridge uhb_bridge_asserts chk_u (.core_clk, .rst, .host_port_ready, .ep_buf_busy,
	.ep_buf_rearm, .register_select_hi, .register_select_lo, .host_rw_n, .host_strobe_n,
	.byte_identify_line, .host_data_oe, .fifo_reset_we, .processor_tick);

// ---- tb/uhb_port_model.sv ----
`timescale 1ns/1ns
module uhb_port_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] slow,
	input  wire logic       sel_hi,
	input  wire logic       sel_lo,
	input  wire logic       rw_n,
	input  wire logic       strobe_n,
	input  wire logic       bil,
	input  wire logic [7:0] data,
	input  wire logic       data_oe,
	output logic            ready,
	output logic [7:0]      cap_lo,
	output logic [7:0]      cap_hi,
	output logic [1:0]      cap_sel,
	output logic [7:0]      xfer_cnt,
	output logic [7:0]      viol
);
	logic       strobe_q;
	logic [7:0] wait_c;
	// bytes are taken as the strobe rises, data still driven then
	always @(posedge clk) begin
		strobe_q <= strobe_n;
		if (rst) begin
			ready    <= 1'b1;
			wait_c   <= 8'h00;
			xfer_cnt <= 8'h00;
			viol     <= 8'h00;
		end else if (strobe_n && !strobe_q) begin
			xfer_cnt <= xfer_cnt + 8'h01;
			// ready, write, driven, low byte first
			if (!ready || rw_n || !data_oe || bil !== xfer_cnt[0])
				viol <= viol + 8'h01;
			if (bil) begin
				cap_hi <= data;
				// internal part of the transfer keeps ready low
				ready  <= 1'b0;
				wait_c <= slow;
			end else begin
				cap_lo  <= data;
				cap_sel <= {sel_hi, sel_lo};
			end
		end else if (wait_c != 8'h00)
			wait_c <= wait_c - 8'h01;
		else
			ready <= 1'b1;
	end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
	import uhb_pkg::*;
	logic        core_clk = 0;
	logic        rst = 1;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0;
	logic        ext_iface_clock = 0;
	logic        ep_buf_busy = 0;
	logic [7:0]  ep_buf_byte0 = 0;
	logic [7:0]  ep_buf_byte1 = 0;
	logic        external_irq_pin = 1;
	logic [7:0]  slow = 8'h04;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, er, ep_buf_rearm, interface_clock, register_select_hi;
	logic        register_select_lo, host_rw_n, host_strobe_n, byte_identify_line;
	logic        host_data_oe, fifo_reset_we, refuse_all_host_traffic, processor_tick;
	logic        host_port_ready;
	logic        seen_s1 = 0;
	logic [2:0]  state_debug_outputs;
	logic [1:0]  cap_sel;
	logic [7:0]  host_data_o, fifo_reset_control, cap_lo, cap_hi, xfer_cnt, viol;
	logic [7:0]  codes[$];
	logic [7:0]  fx[4] = '{8'h80, 8'h82, 8'h86, 8'h00};
	logic [7:0]  cf[5] = '{8'hE6, 8'hA6, 8'h26, 8'hEE, 8'hC6};
	int          ex[5] = '{30, 15, 10, 30, 0};
	int          ext_c = 0;
	int          bad_count = 0;
	int          num_checks = 0;

	always #4 core_clk = ~core_clk;
	// slow external clock, six core cycles per period
	always @(posedge core_clk) begin
		ext_c <= (ext_c == 2) ? 0 : ext_c + 1;
		if (ext_c == 2)
			ext_iface_clock <= ~ext_iface_clock;
	end
	always @(posedge core_clk) begin
		if (fifo_reset_we === 1'b1)
			codes.push_back(fifo_reset_control);
		if (state_debug_outputs === ES_S1)
			seen_s1 <= 1'b1;
	end

	uhb_bridge dut_u (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .ext_iface_clock, .host_port_ready, .ep_buf_busy, .ep_buf_byte0,
		.ep_buf_byte1, .external_irq_pin, .ep_buf_rearm, .interface_clock,
		.state_debug_outputs, .register_select_hi, .register_select_lo, .host_rw_n,
		.host_strobe_n, .byte_identify_line, .host_data_o, .host_data_oe, .fifo_reset_control,
		.fifo_reset_we, .refuse_all_host_traffic, .processor_tick);
	uhb_port_model port_u (.clk(core_clk), .rst, .slow, .sel_hi(register_select_hi),
		.sel_lo(register_select_lo), .rw_n(host_rw_n), .strobe_n(host_strobe_n),
		.bil(byte_identify_line), .data(host_data_o), .data_oe(host_data_oe),
		.ready(host_port_ready), .cap_lo, .cap_hi, .cap_sel, .xfer_cnt, .viol);

	////////////////////////////////////////////////////////////////
	task automatic test_done();
		if (bad_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		num_checks++;
		if (seen !== exp) begin
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
			bad_count++;
		end
	endtask
	task automatic stall(input string nm);
		$display("mismatch %s expected done seen timeout", nm);
		bad_count++;
		test_done();
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge core_clk);
			if (pready === 1'b1)
				break;
		end
		if (n >= 50)
			stall("pready");
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic measure(input int n, output int ic, output int pt);
		logic last;
		last = interface_clock;
		ic = 0;
		pt = 0;
		repeat (n) begin
			@(posedge core_clk);
			ic += (interface_clock !== last);
			pt += (processor_tick === 1'b1);
			last = interface_clock;
		end
	endtask
	task automatic request(input logic [7:0] cmd, b0, b1, input logic [1:0] sel);
		int n;
		logic [7:0] c0;
		c0 = xfer_cnt;
		ep_buf_byte0 <= b0;
		ep_buf_byte1 <= b1;
		ep_buf_busy  <= 1'b1;
		apb(1'b1, A_COMMAND, {24'h0, cmd});
		for (n = 0; n < 200 && ep_buf_rearm !== 1'b1; n++)
			@(posedge core_clk);
		if (n >= 200)
			stall("rearm");
		repeat (30) @(posedge core_clk);
		chk(xfer_cnt, c0, "byte while busy");
		ep_buf_busy <= 1'b0;
		for (n = 0; n < 2000 && xfer_cnt !== c0 + 8'h02; n++)
			@(posedge core_clk);
		if (n >= 2000)
			stall("transfer");
		chk(cap_lo, b0, "first byte");
		chk(cap_hi, b1, "second byte");
		chk(cap_sel, sel, "captured select");
		chk({register_select_hi, register_select_lo}, sel, "select pins");
		chk(viol, 0, "port protocol faults");
		for (n = 0; n < 50; n++) begin
			apb(1'b0, A_STATUS, 0);
			if (rd[3] === 1'b0)
				break;
		end
		if (n >= 50)
			stall("sequencer idle");
		apb(1'b0, A_WF_SELECT, 0);
		chk(rd, 32'h4E, "wave index");
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		int ic;
		int pt;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		apb(1'b0, A_IFACE_CFG, 0);
		chk(rd, 0, "iface cfg reset");
		apb(1'b1, A_EP_CFG, 0);
		apb(1'b0, A_EP_CFG, 0);
		chk(rd, 32'h0000E0A0, "endpoint cfg");
		apb(1'b0, 8'h40, 0);
		chk(er, 1, "unmapped error");
		chk(rd, 0, "unmapped data");
		measure(100, ic, pt);
		chk(pt, 10, "slow ticks");
		apb(1'b1, A_PROC_CTRL, 32'h10);
		// the divider only takes the new rate at its next reload
		repeat (12) @(posedge core_clk);
		measure(100, ic, pt);
		chk(pt, 50, "fast ticks");
		// port mode: pins follow the port register, requests ignored
		apb(1'b1, A_PORT_CTRL, 32'h0E);
		repeat (3) @(posedge core_clk);
		chk({byte_identify_line, register_select_hi, register_select_lo, host_strobe_n,
			host_rw_n}, 32'h0E, "port pins");
		apb(1'b1, A_PORT_CTRL, 32'h13);
		repeat (3) @(posedge core_clk);
		chk({byte_identify_line, register_select_hi, register_select_lo, host_strobe_n,
			host_rw_n}, 32'h13, "port pins");
		apb(1'b1, A_COMMAND, 32'hB6);
		repeat (40) @(posedge core_clk);
		chk(xfer_cnt, 0, "port mode request");
		apb(1'b1, A_FIFO_INIT, 32'h1);
		for (ic = 0; ic < 200 && codes.size() < 4; ic++)
			@(posedge core_clk);
		repeat (2) @(posedge core_clk);
		chk(codes.size(), 4, "fifo code count");
		foreach (fx[i])
			chk(codes[i], fx[i], "fifo code");
		chk(refuse_all_host_traffic, 0, "refuse all after init");
		external_irq_pin <= 1'b0;
		repeat (3) @(posedge core_clk);
		apb(1'b0, A_STATUS, 0);
		chk(rd[7:6], 2'b11, "irq flag set");
		apb(1'b1, A_STATUS, 32'hC0);
		apb(1'b0, A_STATUS, 0);
		chk(rd[7:6], 2'b10, "irq flag cleared");
		external_irq_pin <= 1'b1;
		foreach (cf[i]) begin
			apb(1'b1, A_IFACE_CFG, {24'h0, cf[i]});
			repeat (8) @(posedge core_clk);
			measure(60, ic, pt);
			chk(ic, ex[i], "iface clock toggles");
		end
		request(CMD_CTRL, 8'h5A, 8'h5A, 2'b00);
		chk(seen_s1, 1, "debug state shown");
		slow <= 8'h64;
		request(CMD_ADDR, 8'h34, 8'h12, 2'b10);
		request(CMD_CTRL, 8'hC3, 8'hC3, 2'b00);
		test_done();
	end
endmodule
